// ==== rtl/secs_top.sv ====
`timescale 1ns/100ps
module secs_top
	import secs_pkg::*;
#(
	parameter int ADDR_BITS = ARRAY_ADDR_BITS,
	parameter int WC_COUNT = WC_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	input wire logic wp_n,
	output logic so,
	output logic so_oe,
	input wire logic [1:0] nv_bp_in,
	input wire logic nv_bp_valid,
	output logic [1:0] nv_bp_out,
	output logic nv_bp_we,
	output logic rd_req,
	output logic [ADDR_W_MAX-1:0] rd_addr,
	input wire logic [BYTE_BITS-1:0] rd_data,
	output logic wr_req,
	output secs_array_req_s wr_stage,
	output logic wr_commit,
	output secs_status_s status_out
);

	localparam int WC_W = $clog2(WC_COUNT + 1);
	localparam logic [WC_W-1:0] WC_LOAD = WC_W'(WC_COUNT - 1);
	localparam logic [WC_W-1:0] WC_ONE = WC_W'(1);
	localparam logic [ADDR_W_MAX-1:0] ADDR_MASK = ADDR_W_MAX'((1 << ADDR_BITS) - 1);
	localparam logic [ADDR_W_MAX-1:0] ADDR_ONE = ADDR_W_MAX'(1);

	if (ADDR_BITS < 7 || ADDR_BITS > ADDR_W_MAX) begin : g_bad_addr
		$error("ADDR_BITS must be 7, 8 or 9");
	end
	if (WC_COUNT < 1) begin : g_bad_wc
		$error("WC_COUNT must be at least one");
	end

	function automatic logic op_is(input logic [7:0] b, input logic [2:0] low);
		return (b[7:4] == OP_ZERO_NIBBLE) && (b[2:0] == low);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// pin edges

	logic cs_q;
	logic sck_q;
	logic cs_fall;
	logic cs_rise;
	logic sck_rise;
	logic sck_fall;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cs_q <= 1'b1;
			sck_q <= 1'b0;
		end else begin
			cs_q <= cs_n;
			sck_q <= sck;
		end
	end

	assign cs_fall = cs_q & ~cs_n;
	assign cs_rise = ~cs_q & cs_n;
	assign sck_rise = sck & ~sck_q & ~cs_n;
	assign sck_fall = ~sck & sck_q & ~cs_n;

	////////////////////////////////////////////////////////////////////////
	// serial shifter

	logic [BYTE_BITS-1:0] rx_byte;
	logic rx_done;
	logic [2:0] bit_cnt;
	logic load;
	logic [BYTE_BITS-1:0] load_data;
	logic so_bit;

	// a select fall also restarts the bit count, which doubles as soft reset
	secs_shifter #(
		.DATA_BITS(BYTE_BITS)
	) u_shift (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.clear(cs_n | cs_fall),
		.rise(sck_rise),
		.fall(sck_fall),
		.si(si),
		.load(load),
		.load_data(load_data),
		.rx_byte(rx_byte),
		.rx_done(rx_done),
		.bit_cnt(bit_cnt),
		.so_bit(so_bit)
	);

	////////////////////////////////////////////////////////////////////////
	// opcode decode

	secs_state_e state_reg;
	logic wr_mode_reg;
	logic latch_reg;
	logic busy_reg;
	logic [1:0] bp_reg;
	logic opc_take;
	logic is_set;
	logic is_clr;
	logic is_srd;
	logic is_swr;
	logic is_ard;
	logic is_awr;
	logic wr_ok;
	logic acc_srd;
	logic acc_set;
	logic acc_clr;
	logic acc_swr;
	logic acc_arr;

	assign opc_take = rx_done && !cs_n && (state_reg == ST_OPCODE);
	assign is_set = op_is(rx_byte, OP_SET_LATCH);
	assign is_clr = op_is(rx_byte, OP_CLEAR_LATCH);
	assign is_srd = op_is(rx_byte, OP_STATUS_READ);
	assign is_swr = op_is(rx_byte, OP_STATUS_WRITE);
	assign is_ard = op_is(rx_byte, OP_ARRAY_READ);
	assign is_awr = op_is(rx_byte, OP_ARRAY_WRITE);
	assign wr_ok = latch_reg & wp_n;

	assign acc_srd = opc_take & is_srd;
	assign acc_set = opc_take & is_set & ~busy_reg;
	assign acc_clr = opc_take & is_clr & ~busy_reg;
	assign acc_swr = opc_take & is_swr & ~busy_reg & wr_ok;
	assign acc_arr = opc_take & ~busy_reg & (is_ard | (is_awr & wr_ok));

	////////////////////////////////////////////////////////////////////////
	// sequence state

	always_ff @(posedge core_clk) begin
		if (!rst_n || cs_n) begin
			state_reg <= ST_IDLE;
		end else if (cs_fall) begin
			state_reg <= ST_OPCODE;
		end else begin
			case (state_reg)
				ST_OPCODE: begin
					if (acc_srd) begin
						state_reg <= ST_STAT_TX;
					end else if (acc_swr) begin
						state_reg <= ST_STAT_WR;
					end else if (acc_arr) begin
						state_reg <= ST_ADDR;
					end else if (rx_done) begin
						state_reg <= ST_IGNORE;
					end
				end
				ST_ADDR: begin
					if (rx_done) begin
						state_reg <= wr_mode_reg ? ST_WDATA : ST_RDATA;
					end
				end
				ST_STAT_WR: begin
					if (rx_done) begin
						state_reg <= ST_IGNORE;
					end
				end
				default: state_reg <= state_reg;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// address counter and array requests

	logic addr_hi_reg;
	logic [ADDR_W_MAX-1:0] addr_reg;
	logic addr_locked;
	logic rd_load_q;
	logic any_wr_reg;

	secs_protect #(
		.ADDR_BITS(ADDR_BITS)
	) u_prot (
		.level(bp_reg),
		.addr(addr_reg),
		.is_locked(addr_locked)
	);

	// opcode bit 3 as address msb
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			wr_mode_reg <= 1'b0;
			addr_hi_reg <= 1'b0;
			addr_reg <= '0;
		end else if (acc_arr) begin
			wr_mode_reg <= is_awr;
			addr_hi_reg <= rx_byte[OP_ADDR_BIT];
		end else if (rx_done && state_reg == ST_ADDR) begin
			// smaller densities simply mask the extra bits away
			addr_reg <= {addr_hi_reg, rx_byte} & ADDR_MASK;
		end else if (rx_done && state_reg == ST_RDATA) begin
			addr_reg <= (addr_reg + ADDR_ONE) & ADDR_MASK;
		end else if (rx_done && state_reg == ST_WDATA) begin
			// page writes wrap inside the row
			addr_reg[2:0] <= addr_reg[2:0] + PAGE_STEP;
		end
	end

	// read data is taken one cycle after the request
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rd_req <= 1'b0;
			rd_load_q <= 1'b0;
		end else begin
			rd_req <= rx_done && !cs_n && ((state_reg == ST_ADDR && !wr_mode_reg)
				|| state_reg == ST_RDATA);
			rd_load_q <= rd_req && !cs_n;
		end
	end

	assign rd_addr = addr_reg;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			wr_req <= 1'b0;
			wr_stage <= '0;
		end else begin
			wr_req <= rx_done && !cs_n && state_reg == ST_WDATA && wp_n && !addr_locked;
			if (rx_done && state_reg == ST_WDATA) begin
				wr_stage <= '{addr: addr_reg, data: rx_byte};
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n || cs_fall) begin
			any_wr_reg <= 1'b0;
		end else if (wr_req) begin
			any_wr_reg <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pending effects applied at select rise

	logic set_pend_reg;
	logic sw_pend_reg;
	logic [1:0] pend_bp_reg;
	logic commit_sw;
	logic commit_arr;
	logic wc_start;
	logic wc_done;
	logic [WC_W-1:0] wc_cnt;

	always_ff @(posedge core_clk) begin
		if (!rst_n || cs_fall) begin
			set_pend_reg <= 1'b0;
			sw_pend_reg <= 1'b0;
			pend_bp_reg <= BP_NONE;
		end else if (acc_set) begin
			set_pend_reg <= 1'b1;
		end else if (rx_done && !cs_n && state_reg == ST_STAT_WR) begin
			sw_pend_reg <= 1'b1;
			pend_bp_reg <= rx_byte[STAT_BP_MSB:STAT_BP_LSB];
		end
	end

	// a rise off the byte boundary or with the pin low aborts the write
	// cycle starts at select rise
	assign commit_sw = cs_rise & sw_pend_reg & (bit_cnt == '0) & wp_n;
	assign commit_arr = cs_rise & any_wr_reg & (bit_cnt == '0) & wp_n
		& (state_reg == ST_WDATA);
	assign wc_start = commit_sw | commit_arr;
	assign wc_done = busy_reg && (wc_cnt == '0);

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			wr_commit <= 1'b0;
			nv_bp_we <= 1'b0;
		end else begin
			wr_commit <= commit_arr;
			nv_bp_we <= commit_sw;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// write cycle timer

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			busy_reg <= BUSY_RESET;
			wc_cnt <= '0;
		end else if (wc_start) begin
			busy_reg <= 1'b1;
			wc_cnt <= WC_LOAD;
		end else if (wc_done) begin
			busy_reg <= 1'b0;
		end else if (busy_reg) begin
			wc_cnt <= wc_cnt - WC_ONE;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// status bits

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			latch_reg <= LATCH_RESET;
		end else if (acc_clr) begin
			latch_reg <= 1'b0;
		end else if (cs_rise && set_pend_reg) begin
			latch_reg <= 1'b1;
		end else if (wc_done) begin
			latch_reg <= 1'b0;
		end
	end

	// reset reloads the kept cells; a blank store means factory state
	// protect bits from nonvolatile store
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			bp_reg <= nv_bp_valid ? nv_bp_in : BP_FACTORY;
		end else if (commit_sw) begin
			bp_reg <= pend_bp_reg;
		end
	end

	assign nv_bp_out = bp_reg;

	always_comb begin
		status_out.reserved_nibble = {4{busy_reg}};
		status_out.block_protect_hi = bp_reg[1];
		status_out.block_protect_lo = bp_reg[0];
		status_out.write_enable_latch = latch_reg;
		status_out.busy_flag = busy_reg;
	end

	////////////////////////////////////////////////////////////////////////
	// serial output

	assign load = acc_srd | (rx_done && state_reg == ST_STAT_TX) | rd_load_q;
	assign load_data = rd_load_q ? rd_data : status_out;

	assign so_oe = ~cs_n & (state_reg == ST_STAT_TX || state_reg == ST_RDATA);
	assign so = so_bit;

	////////////////////////////////////////////////////////////////////////
	// checks

	a_set_latch: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(cs_rise && set_pend_reg) |=> latch_reg)
		else $error("latch not set at select rise");

	a_opc_set: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		acc_set |=> set_pend_reg)
		else $error("set request lost");

	a_clear_latch: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		acc_clr |=> !latch_reg)
		else $error("latch not cleared");

	a_cycle_start: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		wc_start |=> busy_reg && status_out.reserved_nibble == 4'hf)
		else $error("write cycle did not start");

	a_busy_ignore: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(opc_take && busy_reg && !is_srd) |=> state_reg == ST_IGNORE)
		else $error("command taken while busy");

	a_cycle_end: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		$fell(busy_reg) |-> !latch_reg && status_out.reserved_nibble == 4'h0)
		else $error("latch still set after cycle");

	a_bp_update: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		commit_sw |=> bp_reg == $past(pend_bp_reg) && nv_bp_we)
		else $error("protect bits not written");

	a_bad_opcode: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(opc_take && !(is_set || is_clr || is_srd || is_swr || is_ard || is_awr))
		|=> state_reg == ST_IGNORE && !so_oe)
		else $error("bad opcode not ignored");

	a_write_gate: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		wr_req |-> latch_reg && $past(wp_n))
		else $error("array write without enable");

	a_no_locked: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		wr_req |-> !$past(addr_locked))
		else $error("write into locked range");

	a_status_load: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		acc_srd |-> load && load_data == status_out)
		else $error("status not loaded");

endmodule

// ==== rtl/secs_pkg.sv ====
package secs_pkg;

	////////////////////////////////////////////////////////////////////////
	// timing
	localparam int CORE_CLK_NS = 25;
	// internal write cycle time; plain default, shorten through the top parameter
	localparam int WC_TIME_NS = 5000000;
	localparam int WC_CYCLES = (WC_TIME_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;

	////////////////////////////////////////////////////////////////////////
	// framing and addressing
	localparam int BYTE_BITS = 8;
	localparam int ADDR_W_MAX = 9;
	localparam int ARRAY_ADDR_BITS = 9;
	localparam int OP_ADDR_BIT = 3;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [2:0] PAGE_STEP = 3'h1;

	////////////////////////////////////////////////////////////////////////
	// opcodes: upper nibble zero, bit 3 free, low three bits select
	localparam logic [3:0] OP_ZERO_NIBBLE = 4'h0;
	localparam logic [2:0] OP_SET_LATCH = 3'h6;
	localparam logic [2:0] OP_CLEAR_LATCH = 3'h4;
	localparam logic [2:0] OP_STATUS_READ = 3'h5;
	localparam logic [2:0] OP_STATUS_WRITE = 3'h1;
	localparam logic [2:0] OP_ARRAY_READ = 3'h3;
	localparam logic [2:0] OP_ARRAY_WRITE = 3'h2;

	////////////////////////////////////////////////////////////////////////
	// status field positions and reset values
	localparam int STAT_BP_LSB = 2;
	localparam int STAT_BP_MSB = 3;
	localparam logic [1:0] BP_NONE = 2'h0;
	localparam logic [1:0] BP_QUARTER = 2'h1;
	localparam logic [1:0] BP_HALF = 2'h2;
	localparam logic [1:0] BP_ALL = 2'h3;
	localparam logic [1:0] BP_FACTORY = BP_NONE;
	localparam logic LATCH_RESET = 1'h0;
	localparam logic BUSY_RESET = 1'h0;

	typedef struct packed {
		logic [3:0] reserved_nibble;
		logic block_protect_hi;
		logic block_protect_lo;
		logic write_enable_latch;
		logic busy_flag;
	} secs_status_s;

	typedef struct packed {
		logic [ADDR_W_MAX-1:0] addr;
		logic [BYTE_BITS-1:0] data;
	} secs_array_req_s;

	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_OPCODE = 8'h02,
		ST_ADDR = 8'h04,
		ST_RDATA = 8'h08,
		ST_WDATA = 8'h10,
		ST_STAT_TX = 8'h20,
		ST_STAT_WR = 8'h40,
		ST_IGNORE = 8'h80
	} secs_state_e;

endpackage

// ==== rtl/secs_shifter.sv ====
`timescale 1ns/100ps
module secs_shifter
	import secs_pkg::*;
#(
	parameter int DATA_BITS = BYTE_BITS
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic rise,
	input wire logic fall,
	input wire logic si,
	input wire logic load,
	input wire logic [DATA_BITS-1:0] load_data,
	output logic [DATA_BITS-1:0] rx_byte,
	output logic rx_done,
	output logic [$clog2(DATA_BITS)-1:0] bit_cnt,
	output logic so_bit
);

	localparam int CNT_W = $clog2(DATA_BITS);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(DATA_BITS - 1);
	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

	if (DATA_BITS < 2 || (1 << CNT_W) != DATA_BITS) begin : g_bad_width
		$error("DATA_BITS must be a power of two");
	end

	logic [DATA_BITS-1:0] sr_reg;
	logic [DATA_BITS-1:0] tx_reg;

	////////////////////////////////////////////////////////////////////////
	// receive side; counter wraps on its own at the byte boundary
	// msb first capture
	always_ff @(posedge core_clk) begin
		if (!rst_n || clear) begin
			sr_reg <= '0;
			bit_cnt <= '0;
		end else if (rise) begin
			sr_reg <= {sr_reg[DATA_BITS-2:0], si};
			bit_cnt <= bit_cnt + CNT_ONE;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rx_byte <= '0;
			rx_done <= 1'b0;
		end else begin
			rx_done <= rise && !clear && (bit_cnt == CNT_LAST);
			if (rise && !clear && (bit_cnt == CNT_LAST)) begin
				rx_byte <= {sr_reg[DATA_BITS-2:0], si};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// transmit side; a load in the same cycle as a falling edge wins,
	// so the master must leave the clock phases long enough
	// msb first output
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			tx_reg <= '0;
			so_bit <= 1'b0;
		end else if (load) begin
			tx_reg <= load_data;
		end else if (fall) begin
			so_bit <= tx_reg[DATA_BITS-1];
			tx_reg <= {tx_reg[DATA_BITS-2:0], 1'b0};
		end
	end

endmodule

// ==== rtl/secs_protect.sv ====
`timescale 1ns/100ps
module secs_protect
	import secs_pkg::*;
#(
	parameter int ADDR_BITS = ARRAY_ADDR_BITS
) (
	input wire logic [1:0] level,
	input wire logic [ADDR_W_MAX-1:0] addr,
	output logic is_locked
);

	if (ADDR_BITS < 2 || ADDR_BITS > ADDR_W_MAX) begin : g_bad_addr
		$error("ADDR_BITS out of range");
	end

	// top two address bits pick the quarter, the top bit the half
	// level encoding
	always_comb begin
		case (level)
			BP_NONE: is_locked = 1'b0;
			BP_QUARTER: is_locked = addr[ADDR_BITS-1] & addr[ADDR_BITS-2];
			BP_HALF: is_locked = addr[ADDR_BITS-1];
			default: is_locked = 1'b1;
		endcase
	end

endmodule

// ==== tb/secs_host.sv ====
`timescale 1ns/100ps
module secs_host
	import secs_pkg::*;
(
	input wire logic core_clk,
	input wire logic so,
	input wire logic so_oe,
	output logic cs_n,
	output logic sck,
	output logic si,
	output logic [7:0] rx_byte,
	output logic rx_stb,
	output logic oe_seen
);
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		si = 1'b0;
		rx_byte = 8'h00;
		rx_stb = 1'b0;
		oe_seen = 1'b0;
	end

	always @(posedge core_clk) begin
		if (!cs_n && so_oe) begin
			oe_seen <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// frame opens at select fall
	task automatic begin_frame();
		@(posedge core_clk);
		oe_seen <= 1'b0;
		cs_n <= 1'b0;
		repeat (3) @(posedge core_clk);
	endtask

	task automatic end_frame();
		repeat (3) @(posedge core_clk);
		cs_n <= 1'b1;
		// released line must not mimic live data
		si <= ~si;
		repeat (4) @(posedge core_clk);
	endtask

	// msb first, six cycles per phase
	task automatic xfer(input logic [7:0] tx, input logic chk);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 7; i >= 0; i--) begin
			si <= tx[i];
			repeat (6) @(posedge core_clk);
			// undriven output reads as the inverted line, not as the last bit
			r[i] = so_oe ? so : ~so;
			sck <= 1'b1;
			repeat (6) @(posedge core_clk);
			sck <= 1'b0;
		end
		rx_byte <= r;
		rx_stb <= chk;
		@(posedge core_clk);
		rx_stb <= 1'b0;
	endtask
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/100ps
module tb_top
	import secs_pkg::*;
;
	localparam int WC_SIM = 600;
	localparam int WAIT_WC = 700;
	localparam logic [8:0] ADDRS [4] = '{9'h0fe, 9'h100, 9'h17e, 9'h180};
	logic core_clk, rst_n, wp_n, nv_bp_valid, cs_n, sck, si, so, so_oe;
	logic nv_bp_we, rd_req, wr_req, wr_commit, rx_stb, oe_seen;
	logic [1:0] nv_bp_in, nv_bp_out;
	logic [ADDR_W_MAX-1:0] rd_addr;
	logic [BYTE_BITS-1:0] rd_data, rx_byte;
	secs_array_req_s wr_stage;
	secs_status_s status_out;
	logic [7:0] q_byte[$];
	secs_array_req_s q_stage[$];
	int n_mismatch, n_tests, cyc, n_commit;

	secs_top #(.ADDR_BITS(9), .WC_COUNT(WC_SIM)) u_secs_top (
		.core_clk(core_clk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .si(si),
		.wp_n(wp_n), .so(so), .so_oe(so_oe), .nv_bp_in(nv_bp_in),
		.nv_bp_valid(nv_bp_valid), .nv_bp_out(nv_bp_out), .nv_bp_we(nv_bp_we),
		.rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data), .wr_req(wr_req),
		.wr_stage(wr_stage), .wr_commit(wr_commit), .status_out(status_out)
	);
	secs_host u_secs_host (
		.core_clk(core_clk), .so(so), .so_oe(so_oe), .cs_n(cs_n), .sck(sck),
		.si(si), .rx_byte(rx_byte), .rx_stb(rx_stb), .oe_seen(oe_seen)
	);

	always #12.5 core_clk = ~core_clk;

	function automatic logic [7:0] mem_val(input logic [8:0] a);
		return a[7:0] ^ {a[8], 7'h2b};
	endfunction
	function automatic logic locked(input logic [1:0] lvl, input logic [8:0] a);
		return (lvl == BP_ALL) || (lvl == BP_HALF && a[8]) || (lvl == BP_QUARTER && a[8:7] == 2'h3);
	endfunction
	function automatic logic [7:0] opc(input logic [2:0] low, input logic b3);
		return {OP_ZERO_NIBBLE, b3, low};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// array and nonvolatile cell stand-ins
	assign rd_data = mem_val(rd_addr);
	always @(posedge core_clk) begin
		if (nv_bp_we) begin
			nv_bp_in <= nv_bp_out;
		end
	end

	task automatic cmp8(input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic cmp_stage(input secs_array_req_s e, input secs_array_req_s g);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic summarize();
		$display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// result watcher; unexpected results meet an unknown note
	always @(posedge core_clk) begin
		cyc++;
		if (wr_commit === 1'b1) n_commit++;
		if (rx_stb === 1'b1) begin
			if (q_byte.size() > 0) cmp8(q_byte.pop_front(), rx_byte);
			else cmp8('x, rx_byte);
		end
		if (wr_req === 1'b1) begin
			if (q_stage.size() > 0) cmp_stage(q_stage.pop_front(), wr_stage);
			else cmp_stage('x, wr_stage);
		end
		if (cyc == 60000) begin
			n_mismatch++;
			summarize();
		end
	end

	task automatic tdone(input string name);
		$display("test %s done", name);
	endtask
	task automatic do_reset();
		@(posedge core_clk);
		rst_n <= 1'b0;
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge core_clk);
	endtask
	task automatic op(input logic [7:0] code);
		u_secs_host.begin_frame();
		u_secs_host.xfer(code, 1'b0);
		u_secs_host.end_frame();
	endtask
	task automatic read_status(input logic [7:0] e);
		q_byte.push_back(e);
		u_secs_host.begin_frame();
		u_secs_host.xfer(opc(OP_STATUS_READ, 1'($urandom)), 1'b0);
		u_secs_host.xfer(8'($urandom), 1'b1);
		u_secs_host.end_frame();
	endtask
	task automatic write_status(input logic [1:0] lvl);
		op(opc(OP_SET_LATCH, 1'($urandom)));
		u_secs_host.begin_frame();
		u_secs_host.xfer(opc(OP_STATUS_WRITE, 1'($urandom)), 1'b0);
		u_secs_host.xfer({4'($urandom), lvl, 2'($urandom)}, 1'b0);
		u_secs_host.end_frame();
	endtask
	// mode 0 normal, 1 latch never set, 2 protect pin low
	task automatic awr(input logic [8:0] a, input logic [1:0] lvl, input int mode);
		logic [8:0] b;
		logic [7:0] d;
		int c0;
		logic any_w;
		c0 = n_commit;
		any_w = 1'b0;
		// pin stays high through set latch
		if (mode != 1) op(opc(OP_SET_LATCH, 1'b0));
		if (mode == 2) wp_n <= 1'b0;
		u_secs_host.begin_frame();
		u_secs_host.xfer({OP_ZERO_NIBBLE, a[8], OP_ARRAY_WRITE}, 1'b0);
		u_secs_host.xfer(a[7:0], 1'b0);
		for (int k = 0; k < 2; k++) begin
			b = {a[8:3], a[2:0] + 3'(k)};
			d = 8'($urandom);
			if (mode == 0 && !locked(lvl, b)) begin
				q_stage.push_back('{addr: b, data: d});
				any_w = 1'b1;
			end
			u_secs_host.xfer(d, 1'b0);
		end
		u_secs_host.end_frame();
		repeat (WAIT_WC) @(posedge core_clk);
		cmp8(8'(n_commit - c0), {7'h00, any_w});
		wp_n <= 1'b1;
	endtask

	initial begin
		logic [1:0] lvl;
		core_clk = 1'b0;
		rst_n = 1'b0;
		wp_n = 1'b1;
		nv_bp_valid = 1'b0;
		n_mismatch = 0;
		n_tests = 0;
		cyc = 0;
		n_commit = 0;
		void'($urandom(16323));
		nv_bp_in = 2'($urandom);
		do_reset();
		nv_bp_valid <= 1'b1;
		read_status(8'h00);
		op(opc(OP_SET_LATCH, 1'($urandom)));
		read_status(8'h02);
		wp_n <= 1'b0;
		op(opc(OP_CLEAR_LATCH, 1'($urandom)));
		wp_n <= 1'b1;
		read_status(8'h00);
		tdone("latch");
		u_secs_host.begin_frame();
		u_secs_host.xfer(8'h16, 1'b0);
		u_secs_host.xfer(8'($urandom), 1'b0);
		u_secs_host.end_frame();
		cmp8({7'h00, oe_seen}, 8'h00);
		read_status(8'h00);
		awr(9'h040, BP_NONE, 1);
		awr(9'h040, BP_NONE, 2);
		read_status(8'h02);
		tdone("refuse");
		for (int i = 0; i < 4; i++) begin
			lvl = 2'(i + 1);
			if (lvl == BP_NONE) begin
				do_reset();
				read_status({4'h0, BP_ALL, 2'h0});
			end
			write_status(lvl);
			read_status({4'hf, lvl, 2'h3});
			op(opc(OP_CLEAR_LATCH, 1'b0));
			read_status({4'hf, lvl, 2'h3});
			repeat (WAIT_WC) @(posedge core_clk);
			read_status({4'h0, lvl, 2'h0});
			for (int j = 0; j < 4; j++) awr(ADDRS[j], lvl, 0);
			tdone("level");
		end
		// read wraps from the top address to zero
		q_byte.push_back(mem_val(9'h1ff));
		q_byte.push_back(mem_val(9'h000));
		u_secs_host.begin_frame();
		u_secs_host.xfer({OP_ZERO_NIBBLE, 1'b1, OP_ARRAY_READ}, 1'b0);
		u_secs_host.xfer(8'hff, 1'b0);
		u_secs_host.xfer(8'($urandom), 1'b1);
		u_secs_host.xfer(8'($urandom), 1'b1);
		u_secs_host.end_frame();
		tdone("read");
		cmp8(8'(q_byte.size() + q_stage.size()), 8'h00);
		summarize();
	end
endmodule
